// ### hw/spg_pkg.sv
// constants, carrier types and phase tables for the step pulse generator
// Function
// - enable low: no new step, up/down or phase activity
// - type 0: direction output low forward, high reverse
// - type 1: up pulses forward, down pulses reverse
// - phases A,B types 2-14; C 3-14; D 5-14; E 11-14
// - step pulse high for programmed length, rise to fall
// - types 0,1: programmed space from fall to next rise
// - zero space allows a step every two ticks; length then one tick
// - type 0: direction setup time before step rise
// - type 0: direction held after step fall
// - types 1 up: reversal delay between opposite steps
// - each type uses only its own timing settings
// - types 2 up: phase change no sooner than pulse length
// - types 2 up: reversal gap at least length plus delay
// - timing settings given in nanoseconds
// - live signed step count updated on each tick that issues a step
// - capture copies count at once; fine feedback of the same instant follows 65 clocks later
// - fine feedback carries position in Q16.16 length units
// - one scale converts commands and feedback
// - unattainable velocity limited to highest attainable; instead the previous rate is held, however far below the limit
// - acceleration limited in both modes
// - velocity mode follows velocity, position mode position
// - current step rate reported in steps per second
// - type 2: A leads B forward, one step per tick
// - type 0: step takes at least two ticks
// - type 3: one phase high, A then B then C
// - position mode by default, velocity selectable
package spg_pkg;
    // clock and tick timing
    localparam int unsigned SPG_CLK_NS      = 5;
    localparam int unsigned SPG_TICK_NS     = 1000;
    localparam int unsigned SPG_TICK_CYCLES = SPG_TICK_NS / SPG_CLK_NS;
    localparam logic [7:0]  SPG_TICK_LAST   = 8'(SPG_TICK_CYCLES - 1);
    // tick period as a 2^-32 fraction of a second, and its square
    localparam logic [15:0] SPG_TICK_K  =
        16'(((64'd1 << 32) * 64'(SPG_TICK_NS)) / 64'd1000000000);
    localparam logic [31:0] SPG_TICK_KK = 32'(SPG_TICK_K) * 32'(SPG_TICK_K);
    localparam logic [20:0] SPG_TICKS_PER_S = 21'(1000000000 / SPG_TICK_NS);
    // position loop gain as a right shift of the error
    localparam int unsigned SPG_PGAIN_SHIFT = 4;
    localparam logic [31:0] SPG_SINCE_MAX   = 32'hffff_ffff;
    localparam logic [6:0]  SPG_DIV_STEPS   = 7'h40;
    localparam logic [3:0]  SPG_LAST_TYPE   = 4'he;

    typedef enum logic [0:0] {
        SPG_LOW  = 1'b0,
        SPG_HIGH = 1'b1
    } spg_state_type;

    typedef struct packed {
        logic [3:0]  step_type;
        logic        vel_mode;  // 0 position, 1 velocity
        logic [31:0] steplen;
        logic [31:0] stepspace;
        logic [31:0] dirhold;
        logic [31:0] dirsetup;
        logic [31:0] dirdelay;
        logic [31:0] maxvel;    // unsigned Q16.16 units/s
        logic [31:0] maxaccel;  // unsigned Q16.16 units/s^2
        logic [31:0] scale;     // unsigned Q16.16 steps/unit
    } spg_cfg_type;

    typedef struct packed {
        logic               enable;
        logic signed [31:0] pos_cmd;  // Q16.16 units
        logic signed [31:0] vel_cmd;  // Q16.16 units/s
    } spg_cmd_type;

    typedef struct packed {
        logic       step;
        logic       dir;
        logic       up;
        logic       down;
        logic [4:0] phase;  // {E,D,C,B,A}
    } spg_pulse_type;

    localparam spg_pulse_type SPG_PULSE_IDLE = '0;

    // pattern states per type, entry 0 first
    localparam logic [3:0] SPG_LEN [0:15] = '{4'h0, 4'h0, 4'h4, 4'h3, 4'h6, 4'h4,
        4'h4, 4'h4, 4'h4, 4'h8, 4'h8, 4'h5, 4'h5, 4'ha, 4'ha, 4'h0};
    localparam logic [4:0] SPG_PAT [0:15][0:9] = '{
        '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h00, 5'h01, 5'h03, 5'h02, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h01, 5'h02, 5'h04, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h01, 5'h03, 5'h02, 5'h06, 5'h04, 5'h05, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h01, 5'h02, 5'h04, 5'h08, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h03, 5'h06, 5'h0c, 5'h09, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h05, 5'h06, 5'h0a, 5'h09, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h09, 5'h0a, 5'h06, 5'h05, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h01, 5'h03, 5'h02, 5'h06, 5'h04, 5'h0c, 5'h08, 5'h09, 5'h00, 5'h00},
        '{5'h05, 5'h04, 5'h06, 5'h02, 5'h0a, 5'h08, 5'h09, 5'h01, 5'h00, 5'h00},
        '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h03, 5'h06, 5'h0c, 5'h18, 5'h11, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00},
        '{5'h01, 5'h03, 5'h02, 5'h06, 5'h04, 5'h0c, 5'h08, 5'h18, 5'h10, 5'h11},
        '{5'h03, 5'h07, 5'h06, 5'h0e, 5'h0c, 5'h1c, 5'h18, 5'h19, 5'h11, 5'h13},
        '{5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00}};
endpackage

// ### hw/spg_core.sv
// one stepper channel: motion profile, step engine, capture and feedback
`timescale 1ns/1ps
module spg_core (
    // clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 reset_n_in,
    // configuration and commands
    input  wire spg_pkg::spg_cfg_type cfg_in,
    input  wire spg_pkg::spg_cmd_type cmd_in,
    input  wire logic                 clear_in,
    input  wire logic                 capture_in,
    // driver pins
    output spg_pkg::spg_pulse_type    pulse_out,
    // feedback
    output logic signed [31:0]        live_count_out,
    output logic signed [31:0]        counts_out,
    output logic signed [31:0]        fine_feedback_out,
    output logic                      fb_valid_out,
    output logic signed [31:0]        step_rate_out
);

    logic [7:0]            tdiv_q;
    logic                  tick_q;
    logic signed [63:0]    pos_q;
    logic signed [63:0]    rate_q;
    logic signed [63:0]    rate_d;
    logic signed [31:0]    live_q;
    logic signed [31:0]    counts_q;
    logic signed [31:0]    fine_q;
    logic signed [31:0]    srate_q;
    logic                  valid_q;
    spg_pkg::spg_pulse_type pulse_q;
    spg_pkg::spg_state_type st_q;
    logic [31:0]           hi_q;
    logic [31:0]           since_q;
    logic [31:0]           sdir_q;
    logic                  rev_q;
    logic [3:0]            idx_q;
    logic [3:0]            typ;
    logic [3:0]            plen;
    logic [3:0]            nidx;
    logic [31:0]           len_t;
    logic [31:0]           spc_t;
    logic [31:0]           hold_t;
    logic [31:0]           setup_t;
    logic [31:0]           dly_t;
    logic [31:0]           per_t;
    logic signed [64:0]    cmd_p;
    logic signed [64:0]    vel_s;
    logic signed [97:0]    vel_p;
    logic [79:0]           maxv_p;
    logic [88:0]           acc_p;
    logic signed [63:0]    maxv;
    logic signed [63:0]    da;
    logic signed [31:0]    pend;
    logic                  pend_small;
    logic                  rev;
    logic                  want;
    logic signed [31:0]    live_n;
    logic signed [84:0]    srate_p;

    // nanoseconds to whole ticks, rounded up
    function automatic logic [31:0] ns2t(input logic [31:0] ns);
        ns2t = 32'((33'(ns) + 33'(spg_pkg::SPG_TICK_NS - 1)) / 33'(spg_pkg::SPG_TICK_NS));
    endfunction

    // fixed-period tick from the system clock
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tdiv_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (tdiv_q == spg_pkg::SPG_TICK_LAST);
            tdiv_q <= (tdiv_q == spg_pkg::SPG_TICK_LAST) ? 8'h00 : tdiv_q + 8'h01;
        end
    end

    // timing settings per type, in ticks; unused ones read as zero
    assign typ     = cfg_in.step_type;
    assign len_t   = (ns2t(cfg_in.steplen) == 32'h0) ? 32'h1 : ns2t(cfg_in.steplen);
    assign spc_t   = (typ < 4'h2) ? ns2t(cfg_in.stepspace) : 32'h0;
    assign hold_t  = (typ == 4'h0) ? ns2t(cfg_in.dirhold) : 32'h0;
    assign setup_t = (typ == 4'h0) ? ns2t(cfg_in.dirsetup) : 32'h0;
    assign dly_t   = (typ != 4'h0) ? ns2t(cfg_in.dirdelay) : 32'h0;
    assign per_t   = (typ < 4'h2) ? len_t + ((spc_t == 32'h0) ? 32'h1 : spc_t) : len_t;

    // unit conversions through the one scale
    assign cmd_p  = $signed(cmd_in.pos_cmd) * $signed({1'b0, cfg_in.scale});
    assign vel_s  = $signed(cmd_in.vel_cmd) * $signed({1'b0, cfg_in.scale});
    assign vel_p  = vel_s * $signed({1'b0, spg_pkg::SPG_TICK_K});
    assign maxv_p = 80'(cfg_in.maxvel) * 80'(cfg_in.scale) * 80'(spg_pkg::SPG_TICK_K);
    assign acc_p  = 89'(cfg_in.maxaccel) * 89'(cfg_in.scale) * 89'(spg_pkg::SPG_TICK_KK);
    assign maxv   = $signed({16'h0, maxv_p[79:32]});
    assign da     = $signed({39'h0, acc_p[88:64]});

    // steps owed by the accumulator to the live count
    assign pend       = pos_q[63:32] - live_q;
    assign pend_small = (pend == 32'sh0) || (pend == 32'sh1) || (pend == -32'sh1);
    assign rev        = pend[31];
    assign plen       = spg_pkg::SPG_LEN[typ];
    assign want = cmd_in.enable && (pend != 32'sh0) && (typ <= spg_pkg::SPG_LAST_TYPE)
                  && ((typ < 4'h2) || (plen != 4'h0));
    assign live_n = rev ? live_q - 32'sh1 : live_q + 32'sh1;
    assign nidx = rev ? (((idx_q == 4'h0) || (idx_q >= plen)) ? plen - 4'h1 : idx_q - 4'h1)
                      : ((idx_q + 4'h1 >= plen) ? 4'h0 : idx_q + 4'h1);

    // velocity target, limit and acceleration ramp
    always_comb begin
        logic signed [63:0] tgt;
        logic signed [63:0] dif;
        logic signed [63:0] nr;
        logic [63:0]        an;
        logic [63:0]        aq;
        logic [95:0]        lim;
        nr  = '0;  // both target branches stay signed so the error keeps its sign
        tgt = cfg_in.vel_mode ? $signed(vel_p[95:32])
                              : ($signed(cmd_p[63:0] - pos_q) >>> spg_pkg::SPG_PGAIN_SHIFT);
        if (tgt > maxv) begin
            tgt = maxv;
        end else if (tgt < -maxv) begin
            tgt = -maxv;
        end
        dif = tgt - rate_q;
        if (dif > da) begin
            nr = rate_q + da;
        end else if (dif < -da) begin
            nr = rate_q - da;
        end else begin
            nr = tgt;
        end
        an  = nr[63] ? 64'(-nr) : 64'(nr);
        aq  = rate_q[63] ? 64'(-rate_q) : 64'(rate_q);
        lim = 96'(an) * 96'(per_t);
        // faster than the pulse timing allows and not slowing down: keep the previous rate
        rate_d = ((lim > 96'h1_0000_0000) && (an >= aq)) ? rate_q : nr;
    end

    // rate and fractional position accumulator
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rate_q <= '0;
            pos_q  <= '0;
        end else if (clear_in) begin
            rate_q <= '0;
            pos_q  <= '0;
        end else if (tick_q) begin
            if (!cmd_in.enable) begin
                rate_q <= '0;
            end else begin
                rate_q <= rate_d;
                if (pend_small) begin
                    pos_q <= pos_q + rate_q;
                end
            end
        end
    end

    // step engine: pulse timing, direction and phase patterns
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q    <= spg_pkg::SPG_LOW;
            pulse_q <= spg_pkg::SPG_PULSE_IDLE;
            live_q  <= '0;
            hi_q    <= '0;
            since_q <= spg_pkg::SPG_SINCE_MAX;
            sdir_q  <= spg_pkg::SPG_SINCE_MAX;
            rev_q   <= 1'b0;
            idx_q   <= '0;
        end else if (clear_in) begin
            st_q    <= spg_pkg::SPG_LOW;
            pulse_q <= spg_pkg::SPG_PULSE_IDLE;
            live_q  <= '0;
            since_q <= spg_pkg::SPG_SINCE_MAX;
            sdir_q  <= spg_pkg::SPG_SINCE_MAX;
        end else if (tick_q) begin
            if (since_q != spg_pkg::SPG_SINCE_MAX) begin
                since_q <= since_q + 32'h1;
            end
            if (sdir_q != spg_pkg::SPG_SINCE_MAX) begin
                sdir_q <= sdir_q + 32'h1;
            end
            if (typ < 4'h2) begin
                pulse_q.phase <= '0;
                if (typ == 4'h1) begin
                    pulse_q.dir <= 1'b0;
                end
                case (st_q)
                    spg_pkg::SPG_HIGH: begin
                        if (hi_q <= 32'h1) begin
                            st_q         <= spg_pkg::SPG_LOW;
                            pulse_q.step <= 1'b0;
                            pulse_q.up   <= 1'b0;
                            pulse_q.down <= 1'b0;
                            since_q      <= 32'h1;
                        end else begin
                            hi_q <= hi_q - 32'h1;
                        end
                    end
                    spg_pkg::SPG_LOW: begin
                        if (want && (typ == 4'h0) && (pulse_q.dir != rev)) begin
                            if (since_q >= hold_t) begin
                                pulse_q.dir <= rev;
                                sdir_q      <= 32'h1;
                            end
                        end else if (want && (since_q >= spc_t) && (sdir_q >= setup_t)
                                     && ((rev == rev_q) || (since_q >= dly_t))) begin
                            st_q   <= spg_pkg::SPG_HIGH;
                            hi_q   <= len_t;
                            rev_q  <= rev;
                            live_q <= live_n;
                            if (typ == 4'h0) begin
                                pulse_q.step <= 1'b1;
                            end else if (rev) begin
                                pulse_q.down <= 1'b1;
                            end else begin
                                pulse_q.up <= 1'b1;
                            end
                        end
                    end
                    default: st_q <= spg_pkg::SPG_LOW;
                endcase
            end else begin
                st_q         <= spg_pkg::SPG_LOW;
                pulse_q.step <= 1'b0;
                pulse_q.dir  <= 1'b0;
                pulse_q.up   <= 1'b0;
                pulse_q.down <= 1'b0;
                if (want && (since_q >= ((rev != rev_q) ? len_t + dly_t : len_t))) begin
                    idx_q         <= nidx;
                    pulse_q.phase <= spg_pkg::SPG_PAT[typ][nidx];
                    since_q       <= 32'h1;
                    rev_q         <= rev;
                    live_q        <= live_n;
                end
            end
        end
    end

    // capture and divide position into length units
    logic [31:0] rem_q;
    logic [63:0] quo_q;
    logic [6:0]  dcnt_q;
    logic        busy_q;
    logic        neg_q;
    logic [32:0] rem_s;
    logic        ge;
    assign rem_s = {rem_q, quo_q[63]};
    assign ge    = rem_s >= {1'b0, cfg_in.scale};

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            counts_q <= '0;
            fine_q   <= '0;
            valid_q  <= 1'b0;
            busy_q   <= 1'b0;
            neg_q    <= 1'b0;
            rem_q    <= '0;
            quo_q    <= '0;
            dcnt_q   <= '0;
        end else if (clear_in) begin
            counts_q <= '0;
            fine_q   <= '0;
            valid_q  <= 1'b0;
            busy_q   <= 1'b0;
        end else if (capture_in) begin
            counts_q <= live_q;
            neg_q    <= live_q[31];
            quo_q    <= live_q[31] ? -{live_q, pos_q[31:0]} : {live_q, pos_q[31:0]};
            rem_q    <= '0;
            dcnt_q   <= '0;
            busy_q   <= 1'b1;
            valid_q  <= 1'b0;
        end else if (busy_q) begin
            if (dcnt_q == spg_pkg::SPG_DIV_STEPS) begin
                fine_q  <= neg_q ? -quo_q[31:0] : quo_q[31:0];
                busy_q  <= 1'b0;
                valid_q <= 1'b1;
            end else begin
                rem_q  <= ge ? 32'(rem_s - {1'b0, cfg_in.scale}) : rem_s[31:0];
                quo_q  <= {quo_q[62:0], ge};
                dcnt_q <= dcnt_q + 7'h01;
            end
        end
    end

    // step rate in whole steps per second; a 16-bit fraction would overflow at tick rates
    assign srate_p = 85'(rate_q) * $signed({1'b0, spg_pkg::SPG_TICKS_PER_S});
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            srate_q <= '0;
        end else begin
            srate_q <= clear_in ? 32'sh0 : srate_p[63:32];
        end
    end

    assign pulse_out         = pulse_q;
    assign live_count_out    = live_q;
    assign counts_out        = counts_q;
    assign fine_feedback_out = fine_q;
    assign fb_valid_out      = valid_q;
    assign step_rate_out     = srate_q;

    // clocks since the last change of step or phase, for the checks
    logic [5:0]  pst_q;
    logic [31:0] gap_q;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pst_q <= '0;
            gap_q <= '0;
        end else begin
            pst_q <= {pulse_q.step, pulse_q.phase};
            gap_q <= (pst_q != {pulse_q.step, pulse_q.phase}) ? 32'h1 : gap_q + 32'h1;
        end
    end

    default clocking spg_cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    a_disabled_no_step: assert property (($rose(pulse_q.step) || $rose(pulse_q.up)
        || $rose(pulse_q.down)) |-> $past(cmd_in.enable)) else $error("step while disabled");
    a_updown_exclusive: assert property (!(pulse_q.up && pulse_q.down))
        else $error("up and down together");
    a_dir_steady_high: assert property (pulse_q.step |-> $stable(pulse_q.dir))
        else $error("direction moved during step");
    a_pulse_high_len: assert property ($fell(pulse_q.step) && !$past(clear_in)
        |-> 40'(gap_q) >= 40'(len_t) * 40'(spg_pkg::SPG_TICK_CYCLES))
        else $error("step pulse too short");
    a_step_space_gap: assert property ($rose(pulse_q.step)
        |-> 40'(gap_q) >= 40'(spc_t) * 40'(spg_pkg::SPG_TICK_CYCLES))
        else $error("step spacing too short");
    a_phase_change_gap: assert property ($changed(pulse_q.phase) && (typ >= 4'h2)
        && $stable(typ) |-> 40'(gap_q) >= 40'(len_t) * 40'(spg_pkg::SPG_TICK_CYCLES))
        else $error("phase changed too soon");
    a_live_count_step: assert property ($rose(pulse_q.step) && !$past(clear_in)
        |-> live_q == (pulse_q.dir ? $past(live_q) - 32'sh1 : $past(live_q) + 32'sh1))
        else $error("live count not stepped");
    a_capture_copy: assert property (capture_in && !clear_in |=> counts_q == $past(live_q)
        ##[1:80] valid_q) else $error("capture failed");
    a_clear_zeroes: assert property (clear_in |=> live_q == 32'sh0 && pos_q == 64'sh0
        && pulse_q == spg_pkg::SPG_PULSE_IDLE ##1 step_rate_out == 32'sh0)
        else $error("clear incomplete");

    c_step_rise: cover property ($rose(pulse_q.step));
    c_dir_change: cover property ($changed(pulse_q.dir) && typ == 4'h0);
    c_phase_step: cover property ($changed(pulse_q.phase) && typ == 4'h2);
    c_feedback_done: cover property ($rose(valid_q));

endmodule // spg_core

// ### verification/spg_driver_model.sv
// driver stage model: counts motor steps from the step/dir or up/down pins
`timescale 1ns/1ps
module spg_driver_model (
    // clock and clear
    input  wire logic                   clock_in,
    input  wire logic                   clear_in,
    // pins from the generator
    input  wire spg_pkg::spg_pulse_type pulse_in,
    // motor position in steps
    output int                          motor_pos_out
);
    logic step_q = 1'b0;
    logic up_q   = 1'b0;
    logic down_q = 1'b0;

    // move one step on each rising edge; direction low means forward
    always @(posedge clock_in) begin
        step_q <= pulse_in.step;
        up_q   <= pulse_in.up;
        down_q <= pulse_in.down;
        if (clear_in) begin
            motor_pos_out <= 0;
        end else if (pulse_in.step && !step_q) begin
            motor_pos_out <= motor_pos_out + (pulse_in.dir ? -1 : 1);
        end else if (pulse_in.up && !up_q) begin
            motor_pos_out <= motor_pos_out + 1;
        end else if (pulse_in.down && !down_q) begin
            motor_pos_out <= motor_pos_out - 1;
        end
    end
endmodule // spg_driver_model

// ### verification/step_pulse_generator_tb_top.sv
// testbench: drives the step pulse generator and checks it against a reference model
`timescale 1ns/1ps
module step_pulse_generator_tb_top;
    // design signals
    logic                   clock_in = 1'b0;
    logic                   reset_n_in = 1'b0;
    spg_pkg::spg_cfg_type   cfg = '0;
    spg_pkg::spg_cmd_type   cmd = '0;
    logic                   clear_in = 1'b0;
    logic                   capture_in = 1'b0;
    spg_pkg::spg_pulse_type pulse_out;
    logic signed [31:0]     live_count_out, counts_out, fine_feedback_out;
    logic                   fb_valid_out;
    logic signed [31:0]     step_rate_out;
    // reference model state
    int                     motor_pos, miscompares = 0, compares = 0;
    int                     expc, hi, lo, dclk, fclk, pclk, len_clk, sp_clk, d, diff;
    logic [31:0]            seed = 32'hd4b3;
    logic                   quiet = 1'b1, act, pa = 1'b0;
    spg_pkg::spg_pulse_type pv = '0;

    always #2.5 clock_in = ~clock_in;

    spg_core dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .cfg_in(cfg), .cmd_in(cmd),
        .clear_in(clear_in), .capture_in(capture_in), .pulse_out(pulse_out),
        .live_count_out(live_count_out), .counts_out(counts_out),
        .fine_feedback_out(fine_feedback_out), .fb_valid_out(fb_valid_out),
        .step_rate_out(step_rate_out));
    spg_driver_model drv (.clock_in(clock_in), .clear_in(clear_in), .pulse_in(pulse_out),
        .motor_pos_out(motor_pos));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // position of a quadrature pattern within its forward cycle
    function automatic int gray_idx(logic [4:0] v);
        return v[1] ? (v[0] ? 2 : 3) : (v[0] ? 1 : 0);
    endfunction

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // reference model: follows the pins, times them and predicts the live count
    always @(negedge clock_in) begin
        act = pulse_out.step | pulse_out.up | pulse_out.down;
        d = 0;
        if (!quiet) begin
            if (act & ~pa & (cfg.step_type < 4'h2)) chk1(lo >= sp_clk, 1'b1);
            if (pa & ~act) chk32(32'(hi), 32'(len_clk));
            if (pulse_out.step & ~pv.step) chk1(dclk >= 400, 1'b1);
            if (pulse_out.dir !== pv.dir) chk1(fclk >= 400, 1'b1);
            if (pulse_out.step & ~pv.step) d = pulse_out.dir ? -1 : 1;
            if (pulse_out.up & ~pv.up) d = 1;
            if (pulse_out.down & ~pv.down) d = -1;
            if (pulse_out.phase !== pv.phase) begin
                chk1(pclk >= len_clk, 1'b1);
                diff = (gray_idx(pulse_out.phase) - gray_idx(pv.phase)) & 3;
                if (cfg.step_type == 4'h2) d = (diff == 1) ? 1 : -1;
                if (cfg.step_type == 4'h2) chk1(diff != 2 && pulse_out.phase[4:2] == 3'h0, 1'b1);
                if (cfg.step_type == 4'h3 && pv.phase != 5'h0)
                    chk32({27'h0, pulse_out.phase}, {29'h0, pv.phase[1:0], pv.phase[2]});
            end
            if (d != 0 && cfg.step_type < 4'h3) begin
                expc = expc + d;
                chk32(live_count_out, 32'(expc));
            end
        end
        hi = act ? hi + 1 : 0;
        lo = act ? 0 : lo + 1;
        dclk = (pulse_out.dir !== pv.dir) ? 1 : dclk + 1;
        fclk = (pa & ~act) ? 1 : fclk + 1;
        pclk = (pulse_out.phase !== pv.phase) ? 1 : pclk + 1;
        pa = act;
        pv = pulse_out;
    end

    // one channel run: clear, move forward then back, stop, capture
    task automatic run(input logic [3:0] t, input logic vm, input int fwd, input int rev);
        logic signed [31:0] vel;
        logic signed [31:0] snap;
        longint             fp;
        longint             rexp;
        vel = 32'h0001_0000 + (rnd() & 32'h7fff);
        quiet = 1'b1;
        clear_in = 1'b1;
        cfg.step_type = t;
        cfg.vel_mode = vm;
        cfg.steplen = 32'd1000 + ((rnd() & 32'h1) * 32'd1000);
        cfg.stepspace = (rnd() & 32'h1) * 32'd1500;
        @(negedge clock_in);
        clear_in = 1'b0;
        @(negedge clock_in);
        chk32(live_count_out, 32'h0);
        chk32(counts_out, 32'h0);
        chk32(step_rate_out, 32'h0);
        expc = 0;
        len_clk = int'((cfg.steplen + 32'd999) / 32'd1000) * 200;
        sp_clk = int'((cfg.stepspace + 32'd999) / 32'd1000) * 200;
        if (sp_clk == 0) sp_clk = 200;
        dclk = 100000;
        fclk = 100000;
        lo = 100000;
        quiet = 1'b0;
        cmd.pos_cmd = 32'h0000_0002;
        cmd.vel_cmd = vel;
        cmd.enable = 1'b1;
        repeat (fwd) @(negedge clock_in);
        rexp = (longint'(vel) * longint'(cfg.scale)) >>> 32;
        if (vm) chk1(longint'(step_rate_out) > rexp - (rexp >>> 8)
            && longint'(step_rate_out) < rexp + (rexp >>> 8), 1'b1);
        cmd.vel_cmd = -vel;
        repeat (rev) @(negedge clock_in);
        cmd.enable = 1'b0;
        repeat (600) @(negedge clock_in);
        snap = live_count_out;
        chk32(step_rate_out, 32'h0);
        repeat (2000) @(negedge clock_in);
        chk32(live_count_out, snap);
        if (t < 4'h2) chk32(live_count_out, 32'(motor_pos));
        capture_in = 1'b1;
        @(negedge clock_in);
        capture_in = 1'b0;
        @(negedge clock_in);
        chk32(counts_out, live_count_out);
        for (int i = 0; i < 80 && fb_valid_out !== 1'b1; i++) @(negedge clock_in);
        chk1(fb_valid_out, 1'b1);
        fp = longint'(fine_feedback_out) * longint'(cfg.scale);
        chk1(fp >= ((longint'(live_count_out) - 1) <<< 32)
            && fp <= ((longint'(live_count_out) + 1) <<< 32), 1'b1);
    endtask

    // main sequence: step/dir, up/down and quadrature in velocity mode, three phase in position
    initial begin
        cfg.dirhold = 32'd1500;
        cfg.dirsetup = 32'd1500;
        cfg.dirdelay = 32'd1500;
        cfg.maxvel = 32'h0010_0000;
        cfg.maxaccel = 32'hffff_ffff;
        cfg.scale = 32'hffff_0000;
        repeat (2) @(negedge clock_in);
        reset_n_in = 1'b1;
        chk32(live_count_out, 32'h0);
        run(4'h0, 1'b1, 10000, 12000);
        run(4'h1, 1'b1, 10000, 12000);
        run(4'h2, 1'b1, 10000, 12000);
        run(4'h3, 1'b0, 16000, 0);
        chk1(live_count_out >= 1 && live_count_out <= 2, 1'b1);
        test_done();
    end

    // watchdog: the sequence needs about 465 us
    initial begin
        #490000;
        miscompares++;
        test_done();
    end
endmodule // step_pulse_generator_tb_top
